// ==== slb_map.vh ====
// Constants for the streaming load line buffer
`ifndef SLB_MAP_VH
`define SLB_MAP_VH

// ==========================================================
// Line and item geometry
`define SLB_LINE_OFS_W   6
`define SLB_ITEM_LSB     4
`define SLB_ITEM_W       2
`define SLB_ITEM_BITS    128
`define SLB_LINE_BITS    512
`define SLB_ITEMS        4

// ==========================================================
// Pool size and idle release count (cycles)
`define SLB_NUM_BUF      4
`define SLB_BUF_IDX_W    2
`define SLB_AGE_LIMIT    64
`define SLB_AGE_W        8

// ==========================================================
// Controller states
`define SLB_ST_IDLE      2'h0
`define SLB_ST_REQ       2'h1
`define SLB_ST_WAIT      2'h2

`endif

// ==== slb_line_entry.v ====
// One streaming line buffer entry: tag, data, read mask and idle age
`timescale 1ns/1ps
`default_nettype none
`include "slb_map.vh"

module slb_line_entry #(
  parameter TAG_W     = 34,
  parameter AGE_LIMIT = `SLB_AGE_LIMIT
) (
  input  wire                       clk_in,
  input  wire                       resetn_in,
  input  wire                       alloc_in,
  input  wire [TAG_W-1:0]           tag_in,
  input  wire [`SLB_LINE_BITS-1:0]  data_in,
  input  wire [`SLB_ITEM_W-1:0]     item_in,
  input  wire                       touch_in,
  input  wire                       inval_in,
  output wire                       valid_out,
  output wire [TAG_W-1:0]           tag_out,
  output wire [`SLB_LINE_BITS-1:0]  data_out,
  output wire [`SLB_ITEMS-1:0]      rmask_out
);

  reg                       valid_ff;
  reg [TAG_W-1:0]           tag_ff;
  reg [`SLB_LINE_BITS-1:0]  data_ff;
  reg [`SLB_ITEMS-1:0]      rmask_ff;
  reg [`SLB_AGE_W-1:0]      age_ff;

  wire [`SLB_ITEMS-1:0] item_bit = {{(`SLB_ITEMS-1){1'b0}}, 1'b1} << item_in;
  wire expired = valid_ff && (age_ff >= AGE_LIMIT[`SLB_AGE_W-1:0]);

  // ==========================================================
  // Control state
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      valid_ff <= 1'b0;
      tag_ff   <= {TAG_W{1'b0}};
      rmask_ff <= {`SLB_ITEMS{1'b0}};
      age_ff   <= {`SLB_AGE_W{1'b0}};
    end
    else if (alloc_in)
    begin
      valid_ff <= 1'b1;
      tag_ff   <= tag_in;
      rmask_ff <= item_bit;
      age_ff   <= {`SLB_AGE_W{1'b0}};
    end
    else if (inval_in || expired)
    begin
      valid_ff <= 1'b0;
      rmask_ff <= {`SLB_ITEMS{1'b0}};
      age_ff   <= {`SLB_AGE_W{1'b0}};
    end
    else if (touch_in)
    begin
      rmask_ff <= rmask_ff | item_bit;
      age_ff   <= {`SLB_AGE_W{1'b0}};
    end
    else if (valid_ff)
    begin
      age_ff <= age_ff + {{(`SLB_AGE_W-1){1'b0}}, 1'b1};
    end
  end

  // Line data needs no reset; valid gates every use
  always @(posedge clk_in)
  begin
    if (alloc_in)
    begin
      data_ff <= data_in;
    end
  end

  assign valid_out = valid_ff;
  assign tag_out   = tag_ff;
  assign data_out  = data_ff;
  assign rmask_out = rmask_ff;

endmodule // slb_line_entry

`default_nettype wire

// ==== slb_stream_buf.v ====
// Streaming load line buffer pool between load issue and memory
// Function
// - Streaming write-combining load fetches whole aligned 64-byte line into a buffer.
// - Later write-combining load to another 16-byte item of a held line answers from buffer.
// - Lines idle too long are released and refetched later.
// - More lines than buffers evicts a line round-robin for refetch.
// - Store hitting a buffered line drops it; next read refetches.
// - Re-reading the same item refetches the whole line.
// - Buffers are not snooped for other agents' writes.
// - Streaming loads may complete weakly ordered.
`timescale 1ns/1ps
`default_nettype none
`include "slb_map.vh"

module slb_stream_buf #(
  parameter ADDR_W    = 40,
  parameter NUM_BUF   = `SLB_NUM_BUF,
  parameter IDX_W     = `SLB_BUF_IDX_W,
  parameter AGE_LIMIT = `SLB_AGE_LIMIT
) (
  input  wire                       clk_in,
  input  wire                       resetn_in,
  input  wire                       ld_valid_in,
  input  wire [ADDR_W-1:0]          ld_addr_in,
  input  wire                       ld_write_combining_memory_type_in,
  output wire                       ld_ready_out,
  output wire                       rsp_valid_out,
  output wire [`SLB_ITEM_BITS-1:0]  rsp_data_out,
  output wire                       rsp_hit_out,
  input  wire                       st_valid_in,
  input  wire [ADDR_W-1:0]          st_addr_in,
  input  wire                       fence_valid_in,
  output wire                       fence_done_out,
  output wire                       mem_req_valid_out,
  output wire [ADDR_W-1:0]          mem_req_addr_out,
  input  wire                       mem_req_ready_in,
  input  wire                       mem_rsp_valid_in,
  input  wire [`SLB_LINE_BITS-1:0]  mem_rsp_data_in
);

  localparam TAG_W = ADDR_W - `SLB_LINE_OFS_W;

  reg [1:0]                  state_ff;
  reg [1:0]                  nxt_state;
  reg [TAG_W-1:0]            req_tag_ff;
  reg [`SLB_ITEM_W-1:0]      req_item_ff;
  reg                        req_wcm_ff;
  reg                        kill_ff;
  reg [IDX_W-1:0]            victim_ff;
  reg [IDX_W-1:0]            rr_ff;
  reg                        rsp_valid_ff;
  reg [`SLB_ITEM_BITS-1:0]   rsp_data_ff;
  reg                        rsp_hit_ff;

  wire [NUM_BUF-1:0]                ent_valid;
  wire [NUM_BUF*TAG_W-1:0]          ent_tag;
  wire [NUM_BUF*`SLB_LINE_BITS-1:0] ent_data;
  wire [NUM_BUF*`SLB_ITEMS-1:0]     ent_rmask;

  // low four bits ignored, loads are taken as aligned
  wire [TAG_W-1:0]       ld_tag  = ld_addr_in[ADDR_W-1:`SLB_LINE_OFS_W];
  wire [`SLB_ITEM_W-1:0] ld_item = ld_addr_in[`SLB_LINE_OFS_W-1:`SLB_ITEM_LSB];
  wire [TAG_W-1:0]       st_tag  = st_addr_in[ADDR_W-1:`SLB_LINE_OFS_W];

  // ==========================================================
  // Lookup
  reg [NUM_BUF-1:0]         hit_vec;
  reg [NUM_BUF-1:0]         reread_vec;
  reg [NUM_BUF-1:0]         st_hit_vec;
  reg [IDX_W-1:0]           hit_idx;
  reg [IDX_W-1:0]           reread_idx;
  reg [IDX_W-1:0]           free_idx;
  reg                       free_any;
  reg [`SLB_ITEM_BITS-1:0]  hit_data;
  integer                   i;

  always @*
  begin
    hit_vec    = {NUM_BUF{1'b0}};
    reread_vec = {NUM_BUF{1'b0}};
    st_hit_vec = {NUM_BUF{1'b0}};
    hit_idx    = {IDX_W{1'b0}};
    reread_idx = {IDX_W{1'b0}};
    free_idx   = {IDX_W{1'b0}};
    free_any   = 1'b0;
    hit_data   = {`SLB_ITEM_BITS{1'b0}};
    for (i = NUM_BUF - 1; i >= 0; i = i - 1)
    begin
      if (ent_valid[i] && (ent_tag[i*TAG_W +: TAG_W] == ld_tag))
      begin
        // item already read counts as miss
        if (ent_rmask[i*`SLB_ITEMS + ld_item])
        begin
          reread_vec[i] = 1'b1;
          reread_idx    = i[IDX_W-1:0];
        end
        else
        begin
          hit_vec[i] = 1'b1;
          hit_idx    = i[IDX_W-1:0];
          hit_data   = ent_data[i*`SLB_LINE_BITS + ld_item*`SLB_ITEM_BITS +: `SLB_ITEM_BITS];
        end
      end
      // only this core's own stores are looked at
      if (ent_valid[i] && (ent_tag[i*TAG_W +: TAG_W] == st_tag))
      begin
        st_hit_vec[i] = st_valid_in;
      end
      if (!ent_valid[i])
      begin
        free_any = 1'b1;
        free_idx = i[IDX_W-1:0];
      end
    end
  end

  // ==========================================================
  // Control
  wire idle       = (state_ff == `SLB_ST_IDLE);
  // fence taken only with nothing outstanding, ahead of loads
  wire fence_take = idle && fence_valid_in;
  wire accept     = idle && !fence_valid_in && ld_valid_in;
  wire buf_hit    = ld_write_combining_memory_type_in && (|hit_vec);
  wire acc_hit    = accept && buf_hit;
  wire acc_miss   = accept && !buf_hit;
  wire fill       = (state_ff == `SLB_ST_WAIT) && mem_rsp_valid_in;
  // Stale fill must not be kept once the core stored into that line
  wire alloc_fire = fill && req_wcm_ff && !kill_ff && !(st_valid_in && (st_tag == req_tag_ff));

  // reuse re-read entry, then a free one, then round-robin victim
  wire [IDX_W-1:0] nxt_victim = (|reread_vec) ? reread_idx : (free_any ? free_idx : rr_ff);

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      `SLB_ST_IDLE:
      begin
        if (acc_miss)
        begin
          nxt_state = `SLB_ST_REQ;
        end
      end
      `SLB_ST_REQ:
      begin
        if (mem_req_ready_in)
        begin
          nxt_state = `SLB_ST_WAIT;
        end
      end
      `SLB_ST_WAIT:
      begin
        if (mem_rsp_valid_in)
        begin
          nxt_state = `SLB_ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = `SLB_ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_ff     <= `SLB_ST_IDLE;
      req_tag_ff   <= {TAG_W{1'b0}};
      req_item_ff  <= {`SLB_ITEM_W{1'b0}};
      req_wcm_ff   <= 1'b0;
      kill_ff      <= 1'b0;
      victim_ff    <= {IDX_W{1'b0}};
      rr_ff        <= {IDX_W{1'b0}};
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= {`SLB_ITEM_BITS{1'b0}};
      rsp_hit_ff   <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      rsp_valid_ff <= acc_hit | fill;
      if (acc_miss)
      begin
        // whole line fetched on a miss
        req_tag_ff  <= ld_tag;
        req_item_ff <= ld_item;
        req_wcm_ff  <= ld_write_combining_memory_type_in;
        victim_ff   <= nxt_victim;
        kill_ff     <= st_valid_in && (st_tag == ld_tag);
      end
      else if (st_valid_in && (st_tag == req_tag_ff) && !idle)
      begin
        // store during fetch spoils the fill
        kill_ff <= 1'b1;
      end
      if (acc_hit)
      begin
        rsp_data_ff <= hit_data;
        rsp_hit_ff  <= 1'b1;
      end
      else if (fill)
      begin
        rsp_data_ff <= mem_rsp_data_in[req_item_ff*`SLB_ITEM_BITS +: `SLB_ITEM_BITS];
        rsp_hit_ff  <= 1'b0;
      end
      if (alloc_fire && (victim_ff == rr_ff))
      begin
        rr_ff <= rr_ff + {{(IDX_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==========================================================
  // Entry pool
  genvar g;
  generate
    for (g = 0; g < NUM_BUF; g = g + 1)
    begin : g_ent
      // own store drops line; fence clears all; re-read drops
      wire inval = fence_take | st_hit_vec[g] | (acc_miss && (|reread_vec) && (reread_idx == g));
      slb_line_entry #(
        .TAG_W     (TAG_W),
        .AGE_LIMIT (AGE_LIMIT)
      ) u_ent (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .alloc_in  (alloc_fire && (victim_ff == g)),
        .tag_in    (req_tag_ff),
        .data_in   (mem_rsp_data_in),
        .item_in   (alloc_fire ? req_item_ff : ld_item),
        .touch_in  (acc_hit && (hit_idx == g)),
        .inval_in  (inval),
        .valid_out (ent_valid[g]),
        .tag_out   (ent_tag[g*TAG_W +: TAG_W]),
        .data_out  (ent_data[g*`SLB_LINE_BITS +: `SLB_LINE_BITS]),
        .rmask_out (ent_rmask[g*`SLB_ITEMS +: `SLB_ITEMS])
      );
    end
  endgenerate

  // ==========================================================
  // Outputs
  // hits may answer ahead of other memory traffic; no ordering kept
  assign ld_ready_out      = idle && !fence_valid_in;
  assign fence_done_out    = fence_take;
  assign mem_req_valid_out = (state_ff == `SLB_ST_REQ);
  assign mem_req_addr_out  = {req_tag_ff, {`SLB_LINE_OFS_W{1'b0}}};
  assign rsp_valid_out     = rsp_valid_ff;
  assign rsp_data_out      = rsp_data_ff;
  assign rsp_hit_out       = rsp_hit_ff;

endmodule // slb_stream_buf

`default_nettype wire

// ==== slb_monitor.sv ====
// Port checker for the streaming load line buffer
`timescale 1ns/1ps
`default_nettype none
module slb_monitor #(parameter ADDR_W = 40) (
  input wire logic              clk_in,
  input wire logic              resetn_in,
  input wire logic              ld_valid_in,
  input wire logic [ADDR_W-1:0] ld_addr_in,
  input wire logic              ld_write_combining_memory_type_in,
  input wire logic              ld_ready_out,
  input wire logic              rsp_valid_out,
  input wire logic              rsp_hit_out,
  input wire logic              fence_valid_in,
  input wire logic              fence_done_out,
  input wire logic              mem_req_valid_out,
  input wire logic [ADDR_W-1:0] mem_req_addr_out,
  input wire logic              mem_req_ready_in,
  input wire logic              mem_rsp_valid_in
);
  logic [ADDR_W-7:0] last_line_ff;
  always_ff @(posedge clk_in) last_line_ff <= ld_addr_in[ADDR_W-1:6];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ==========================================================
  // Sequences
  sequence s_take; ld_valid_in && ld_ready_out; endsequence
  sequence s_hit; rsp_valid_out && rsp_hit_out; endsequence
  // ==========================================================
  // Properties
  property p_hit_src; s_hit |-> $past(ld_valid_in && ld_ready_out && ld_write_combining_memory_type_in); endproperty
  a_hit_src: assert property (p_hit_src) else $error("hit answer without a load");
  property p_hit_nofetch; s_take ##1 s_hit |-> !mem_req_valid_out; endproperty
  a_hit_nofetch: assert property (p_hit_nofetch) else $error("hit also fetched");
  property p_miss_src; rsp_valid_out && !rsp_hit_out |-> $past(mem_rsp_valid_in); endproperty
  a_miss_src: assert property (p_miss_src) else $error("miss answer without line");
  property p_line_align; mem_req_valid_out |-> mem_req_addr_out[5:0] == 6'h00; endproperty
  a_line_align: assert property (p_line_align) else $error("request not line aligned");
  property p_req_hold; mem_req_valid_out && !mem_req_ready_in |=> mem_req_valid_out && $stable(mem_req_addr_out);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_nowc_fetch; s_take and !ld_write_combining_memory_type_in
    |=> mem_req_valid_out && mem_req_addr_out == {last_line_ff, 6'h00}; endproperty
  a_nowc_fetch: assert property (p_nowc_fetch) else $error("uncached load not fetched");
  property p_fence_block; fence_valid_in |-> !ld_ready_out; endproperty
  a_fence_block: assert property (p_fence_block) else $error("load taken under fence");
  property p_fence_clear; fence_done_out ##[1:3] s_take |=> !rsp_hit_out || !rsp_valid_out; endproperty
  a_fence_clear: assert property (p_fence_clear) else $error("hit right after fence");
  property p_one_out; mem_req_valid_out |-> !ld_ready_out && !fence_done_out; endproperty
  a_one_out: assert property (p_one_out) else $error("load taken during miss");
endmodule // slb_monitor
`default_nettype wire

// ==== slb_mem_model.sv ====
// Memory side model answering line fetches
`timescale 1ns/1ps
`default_nettype none
module slb_mem_model (
  input  wire logic        clk_in,
  input  wire logic        req_valid_in,
  input  wire logic [39:0] req_addr_in,
  input  wire logic [7:0]  ver_in,
  input  wire logic [3:0]  dly_in,
  output var  logic        req_ready_out,
  output var  logic        rsp_valid_out,
  output var  logic [511:0] rsp_data_out,
  output var  int          fetches_out
);
  logic [39:0] line_ff;
  int          cnt_ff;
  initial
  begin
    {req_ready_out, rsp_valid_out, rsp_data_out} = '0;
    fetches_out = 0;
    cnt_ff = 0;
  end
  // ==========================================================
  // Plain memory; reads have no side effects
  // safe read target
  always @(negedge clk_in)
  begin
    req_ready_out <= 1'b0;
    rsp_valid_out <= 1'b0;
    // Data toggles outside the pulse so stale reads show
    rsp_data_out <= ~rsp_data_out;
    if (cnt_ff == 1)
    begin
      rsp_valid_out <= 1'b1;
      for (int k = 0; k < 4; k++)
        rsp_data_out[k*128+:128] <= {ver_in, 80'h0, line_ff[39:6], k[1:0], 4'h0};
    end
    if (cnt_ff > 0)
      cnt_ff <= cnt_ff - 1;
    else if (req_valid_in && !req_ready_out)
    begin
      req_ready_out <= 1'b1;
      line_ff <= req_addr_in;
      cnt_ff <= dly_in + 1;
      fetches_out <= fetches_out + 1;
    end
  end
endmodule // slb_mem_model
`default_nettype wire

// ==== slb_stream_buf_tb_top.sv ====
// Self-checking bench for the streaming load line buffer
`timescale 1ns/1ps
`default_nettype none
module slb_stream_buf_tb_top;
  typedef struct {logic [39:0] a; logic wc; logic hit;} slb_row_t;
  logic clk_in, resetn_in, ld_valid_in, ld_write_combining_memory_type_in, st_valid_in, fence_valid_in;
  logic ld_ready_out, rsp_valid_out, rsp_hit_out, fence_done_out, mem_req_valid_out;
  logic mem_req_ready_in, mem_rsp_valid_in;
  logic [39:0] ld_addr_in, st_addr_in, mem_req_addr_out;
  logic [127:0] rsp_data_out;
  logic [511:0] mem_rsp_data_in;
  logic [7:0] ver;
  logic [3:0] dly;
  int fetches, checks, miscompares, cycles, misses;
  slb_row_t rows [0:6];
  slb_stream_buf #(.AGE_LIMIT(64)) u_dut (.clk_in, .resetn_in, .ld_valid_in, .ld_addr_in,
    .ld_write_combining_memory_type_in, .ld_ready_out, .rsp_valid_out, .rsp_data_out, .rsp_hit_out,
    .st_valid_in, .st_addr_in, .fence_valid_in, .fence_done_out, .mem_req_valid_out, .mem_req_addr_out,
    .mem_req_ready_in, .mem_rsp_valid_in, .mem_rsp_data_in);
  slb_mem_model u_mem (.clk_in, .req_valid_in(mem_req_valid_out), .req_addr_in(mem_req_addr_out),
    .ver_in(ver), .dly_in(dly), .req_ready_out(mem_req_ready_in), .rsp_valid_out(mem_rsp_valid_in),
    .rsp_data_out(mem_rsp_data_in), .fetches_out(fetches));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ==========================================================
  // Checking and bus tasks
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // callers pass 16-byte aligned addresses only
  task automatic ld(input logic [39:0] a, input logic wc);
    int n;
    n = 0;
    @(negedge clk_in);
    {ld_valid_in, ld_addr_in, ld_write_combining_memory_type_in} = {1'b1, a, wc};
    while (ld_ready_out !== 1'b1 && n < 200)
    begin
      @(negedge clk_in);
      n++;
    end
    @(negedge clk_in);
    ld_valid_in = 1'b0;
    while (rsp_valid_out !== 1'b1 && n < 200)
    begin
      @(negedge clk_in);
      n++;
    end
    // Handshake limit running out is a failure
    if (n >= 200) miscompares++;
  endtask
  task automatic ldc(input logic [39:0] a, input logic wc, input logic hit, input logic [7:0] v);
    int f0;
    f0 = fetches;
    ld(a, wc);
    check(rsp_hit_out, hit);
    check(rsp_data_out, {v, 80'h0, a[39:4], 4'h0});
    check(fetches - f0, !hit);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    {ld_valid_in, ld_write_combining_memory_type_in, st_valid_in, fence_valid_in} = '0;
    {ld_addr_in, st_addr_in, ver, dly, resetn_in} = {80'h0, 8'h00, 4'h1, 1'b0};
    rows = '{'{40'h1000, 1, 0}, '{40'h1010, 1, 1}, '{40'h1030, 1, 1}, '{40'h1010, 1, 0},
             '{40'h1020, 1, 1}, '{40'h2000, 0, 0}, '{40'h2010, 0, 0}};
    repeat (10) @(negedge clk_in);
    check({ld_ready_out, rsp_valid_out, mem_req_valid_out}, 3'h4);
    resetn_in = 1'b1;
    $display("test reset done");
    foreach (rows[i])
      ldc(rows[i].a, rows[i].wc, rows[i].hit, 8'h00);
    $display("test table done");
    ldc(40'h8000, 1, 0, 8'h00);
    repeat (80) @(negedge clk_in);
    ldc(40'h8010, 1, 0, 8'h00);
    dly = 4'h9;
    ldc(40'h9000, 1, 0, 8'h00);
    {st_valid_in, st_addr_in} = {1'b1, 40'h9020};
    @(negedge clk_in);
    st_valid_in = 1'b0;
    ldc(40'h9010, 1, 0, 8'h00);
    // Store lands while the line is still being fetched
    fork
      ldc(40'hA000, 1, 0, 8'h00);
      begin
        repeat (3) @(negedge clk_in);
        {st_valid_in, st_addr_in} = {1'b1, 40'hA030};
        @(negedge clk_in);
        st_valid_in = 1'b0;
      end
    join
    ldc(40'hA010, 1, 0, 8'h00);
    ldc(40'hB000, 1, 0, 8'h00);
    // consumer relies on fences, not on coherence
    // Other agent rewrites the line behind the buffer
    ver = 8'h01;
    ldc(40'hB010, 1, 1, 8'h00);
    @(negedge clk_in);
    fence_valid_in = 1'b1;
    #1;
    check(fence_done_out, 1);
    @(negedge clk_in);
    fence_valid_in = 1'b0;
    ldc(40'hB020, 1, 0, 8'h01);
    $display("test hazards done");
    dly = 4'h1;
    for (int i = 3; i < 8; i++)
      ldc({28'h0, i[3:0], 8'h00}, 1, 0, 8'h01);
    misses = 0;
    for (int i = 3; i < 8; i++)
    begin
      ld({28'h0, i[3:0], 8'h10}, 1);
      misses += (rsp_hit_out !== 1'b1);
    end
    check(misses != 0, 1);
    $display("test eviction done");
    // Reset in mid-run must drop every held line
    ldc(40'hC000, 1, 0, 8'h01);
    resetn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    ldc(40'hC010, 1, 0, 8'h01);
    $display("test midrun reset done");
    end_of_test;
  end
  // ==========================================================
  // Hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      end_of_test;
    end
  end
endmodule // slb_stream_buf_tb_top
bind slb_stream_buf slb_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk_in, .resetn_in, .ld_valid_in, .ld_addr_in,
  .ld_write_combining_memory_type_in, .ld_ready_out, .rsp_valid_out, .rsp_hit_out, .fence_valid_in,
  .fence_done_out, .mem_req_valid_out, .mem_req_addr_out, .mem_req_ready_in, .mem_rsp_valid_in);
`default_nettype wire
